/* File: verilog/pdobr_regs.sv */
// What this block does
// - Power register bit 5 high turns the sampling clock buffer off.
// - Power register bit 4 high turns the reference gain amplifier off.
// - Power register bit 2 high turns conversion channel A off.
// - Power register bit 1 high turns conversion channel B off.
// - Power register bit 0 enters whole-chip sleep, scoped by mask register.
// - In sleep, clock buffer and amplifier stay on only if masked.
// - Three registers form a 24-bit field, each high bit disables a buffer.
// - Fixed bit-to-pin mapping for clock, frame clock and data lines.
// - Clock input needs extra enables; data clock output off elsewhere.
module pdobr_regs (
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  input  wire logic                sclk,
  input  wire logic                sen_n,
  input  wire logic                sdio_in,
  output logic                     sdio_out,
  output logic                     sdio_oe,
  output pdobr_pkg::pdobr_power_t  power_ctl,
  output pdobr_pkg::pdobr_pins_t   pin_ctl,
  output logic [23:0]              output_driver_disable_bits
);

  // -----------------------------------------------------------------
  // Register state
  // -----------------------------------------------------------------
  pdobr_pkg::pdobr_req_t req;
  logic                  req_valid;
  logic [6:0]            rd_addr;
  logic [7:0]            rd_data;
  logic [7:0]            block_power_down_control;
  logic [7:0]            sleep_mask;
  logic [23:0]           obd;
  logic [7:0]            clkin_ctl;
  logic [7:0]            clkpin_ctl;
  logic                  wr_en;
  logic                  whole_chip_sleep;

  function automatic logic hit(input logic [6:0] a, input logic [6:0] off);
    hit = (a == off);
  endfunction

  pdobr_serial_port u_port (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .sclk      (sclk),
    .sen_n     (sen_n),
    .sdio_in   (sdio_in),
    .rd_data   (rd_data),
    .req       (req),
    .req_valid (req_valid),
    .rd_addr   (rd_addr),
    .sdio_out  (sdio_out),
    .sdio_oe   (sdio_oe)
  );

  assign wr_en = req_valid & req.wr;
  assign whole_chip_sleep = block_power_down_control[pdobr_pkg::PWR_GLOBAL];

  // -----------------------------------------------------------------
  // Register writes
  // -----------------------------------------------------------------
  // Bits software must leave at zero are still stored, so a read shows
  // exactly what was written and a mistake is visible
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      block_power_down_control <= pdobr_pkg::RESET_BYTE;
    else if (wr_en && hit(req.addr, pdobr_pkg::ADDR_POWER))
      block_power_down_control <= req.data;

  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      sleep_mask <= pdobr_pkg::RESET_BYTE;
    else if (wr_en && hit(req.addr, pdobr_pkg::ADDR_SLEEP_MASK))
      sleep_mask <= req.data;

  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      obd <= pdobr_pkg::RESET_OBD;
    else if (wr_en && hit(req.addr, pdobr_pkg::ADDR_OBD_LOW))
      obd[7:0] <= req.data;
    else if (wr_en && hit(req.addr, pdobr_pkg::ADDR_OBD_MID))
      obd[15:8] <= req.data;
    else if (wr_en && hit(req.addr, pdobr_pkg::ADDR_OBD_HIGH))
      obd[23:16] <= req.data;

  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      clkin_ctl <= pdobr_pkg::RESET_BYTE;
    else if (wr_en && hit(req.addr, pdobr_pkg::ADDR_CLKIN_CTL))
      clkin_ctl <= req.data;

  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      clkpin_ctl <= pdobr_pkg::RESET_BYTE;
    else if (wr_en && hit(req.addr, pdobr_pkg::ADDR_CLKPIN_CTL))
      clkpin_ctl <= req.data;

  // -----------------------------------------------------------------
  // Read mux
  // -----------------------------------------------------------------
  always_comb
  begin
    if (hit(rd_addr, pdobr_pkg::ADDR_POWER))
      rd_data = block_power_down_control;
    else if (hit(rd_addr, pdobr_pkg::ADDR_OBD_LOW))
      rd_data = obd[7:0];
    else if (hit(rd_addr, pdobr_pkg::ADDR_OBD_MID))
      rd_data = obd[15:8];
    else if (hit(rd_addr, pdobr_pkg::ADDR_OBD_HIGH))
      rd_data = obd[23:16];
    else if (hit(rd_addr, pdobr_pkg::ADDR_SLEEP_MASK))
      rd_data = sleep_mask;
    else if (hit(rd_addr, pdobr_pkg::ADDR_CLKIN_CTL))
      rd_data = clkin_ctl;
    else if (hit(rd_addr, pdobr_pkg::ADDR_CLKPIN_CTL))
      rd_data = clkpin_ctl;
    else
      rd_data = pdobr_pkg::READ_UNMAPPED;
  end

  // -----------------------------------------------------------------
  // Power controls
  // -----------------------------------------------------------------
  // Registered once more so every output leaves from a flip-flop; costs
  // one cycle of latency, irrelevant against analog settling
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      power_ctl <= '0;
    else
    begin
      power_ctl.sample_clock_buffer_off <=
        block_power_down_control[pdobr_pkg::PWR_CLKBUF] |
        (whole_chip_sleep & ~sleep_mask[pdobr_pkg::MASK_CLKBUF]);
      power_ctl.reference_amplifier_off <=
        block_power_down_control[pdobr_pkg::PWR_AMP] |
        (whole_chip_sleep & ~sleep_mask[pdobr_pkg::MASK_AMP]);
      power_ctl.bandgap_off <=
        whole_chip_sleep & sleep_mask[pdobr_pkg::MASK_BGAP];
      power_ctl.channel_first_off <=
        block_power_down_control[pdobr_pkg::PWR_CHAN_A] |
        whole_chip_sleep;
      power_ctl.channel_second_off <=
        block_power_down_control[pdobr_pkg::PWR_CHAN_B] |
        whole_chip_sleep;
    end

  // -----------------------------------------------------------------
  // Output buffer controls
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      output_driver_disable_bits <= pdobr_pkg::RESET_OBD;
      pin_ctl                    <= '0;
    end
    else
    begin
      output_driver_disable_bits <= obd;
      // Input clock buffer needs both extra enables and no disable bit
      pin_ctl.data_clock_input_pin_en <=
        ~obd[pdobr_pkg::OBD_CLKIN] &
        clkin_ctl[pdobr_pkg::CLKIN_EN_18] &
        clkpin_ctl[pdobr_pkg::CLKIN_EN_1F];
      pin_ctl.data_clock_output_pin_off <=
        clkpin_ctl[pdobr_pkg::CLKOUT_OFF];
      pin_ctl.frame_clock_pin_off <= obd[pdobr_pkg::OBD_FRAME];
      pin_ctl.second_channel_line_five_off <= obd[pdobr_pkg::OBD_B5];
      pin_ctl.second_channel_line_six_off <= obd[pdobr_pkg::OBD_B6];
      pin_ctl.first_channel_line_five_off <= obd[pdobr_pkg::OBD_A5];
      pin_ctl.first_channel_line_six_off <= obd[pdobr_pkg::OBD_A6];
    end

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  logic wr_pwr;
  logic wr_low;
  logic wr_mid;
  logic wr_high;
  logic wr_pin;
  assign wr_pwr  = wr_en && hit(req.addr, pdobr_pkg::ADDR_POWER);
  assign wr_low  = wr_en && hit(req.addr, pdobr_pkg::ADDR_OBD_LOW);
  assign wr_mid  = wr_en && hit(req.addr, pdobr_pkg::ADDR_OBD_MID);
  assign wr_high = wr_en && hit(req.addr, pdobr_pkg::ADDR_OBD_HIGH);
  assign wr_pin  = wr_en && hit(req.addr, pdobr_pkg::ADDR_CLKPIN_CTL);

  property p_clkbuf;
    @(posedge clk_sys) disable iff (!rst_n)
    wr_pwr |-> ##2 (power_ctl.sample_clock_buffer_off ==
      ($past(req.data[5], 2) | ($past(req.data[0], 2) & ~sleep_mask[3])));
  endproperty
  a_clkbuf: assert property (p_clkbuf)
    else $error("clock buffer power-down wrong after write");

  property p_ref_amp;
    @(posedge clk_sys) disable iff (!rst_n)
    (wr_pwr && req.data[4]) |-> ##2 power_ctl.reference_amplifier_off;
  endproperty
  a_ref_amp: assert property (p_ref_amp)
    else $error("amplifier not powered down after write");

  property p_chan_a;
    @(posedge clk_sys) disable iff (!rst_n)
    (wr_pwr && req.data[2:0] == 3'h0) |-> ##2
      (!power_ctl.channel_first_off && !power_ctl.channel_second_off);
  endproperty
  a_chan_a: assert property (p_chan_a)
    else $error("channel off with its bit and sleep clear");

  property p_chan_b;
    @(posedge clk_sys) disable iff (!rst_n)
    (wr_pwr && req.data[1]) |-> ##2
      (power_ctl.channel_second_off [*2]);
  endproperty
  a_chan_b: assert property (p_chan_b)
    else $error("channel B not powered down");

  property p_sleep;
    @(posedge clk_sys) disable iff (!rst_n)
    (wr_pwr && req.data[0]) |-> ##2
      (power_ctl.channel_first_off && power_ctl.channel_second_off);
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep did not stop both channels");

  property p_mask;
    @(posedge clk_sys) disable iff (!rst_n)
    (whole_chip_sleep && !block_power_down_control[4]) |=>
      (power_ctl.reference_amplifier_off == !$past(sleep_mask[2]))
      && (power_ctl.bandgap_off == $past(sleep_mask[1]));
  endproperty
  a_mask: assert property (p_mask)
    else $error("sleep mask not honoured");

  property p_field;
    @(posedge clk_sys) disable iff (!rst_n)
    wr_low |-> ##2
      (output_driver_disable_bits[7:0] == $past(req.data, 2));
  endproperty
  a_field: assert property (p_field)
    else $error("disable field low byte mismatch");

  property p_map;
    @(posedge clk_sys) disable iff (!rst_n)
    wr_high |-> ##2
      (pin_ctl.first_channel_line_five_off == $past(req.data[0], 2))
      && (pin_ctl.first_channel_line_six_off == $past(req.data[1], 2));
  endproperty
  a_map: assert property (p_map)
    else $error("first channel line mapping wrong");

  property p_clkout;
    @(posedge clk_sys) disable iff (!rst_n)
    wr_pin |-> ##2
      (pin_ctl.data_clock_output_pin_off == $past(req.data[4], 2));
  endproperty
  a_clkout: assert property (p_clkout)
    else $error("data clock output control wrong");

  property p_mid;
    @(posedge clk_sys) disable iff (!rst_n)
    wr_mid |-> ##2
      (output_driver_disable_bits[15:8] == $past(req.data, 2));
  endproperty
  a_mid: assert property (p_mid)
    else $error("disable field middle byte mismatch");

  property p_frame;
    @(posedge clk_sys) disable iff (!rst_n)
    wr_mid |-> ##2
      (pin_ctl.frame_clock_pin_off == $past(req.data[4], 2))
      && (pin_ctl.second_channel_line_six_off == $past(req.data[0], 2));
  endproperty
  a_frame: assert property (p_frame)
    else $error("frame clock or second channel mapping wrong");

  property p_clkin;
    @(posedge clk_sys) disable iff (!rst_n)
    pin_ctl.data_clock_input_pin_en ==
      ($past(clkin_ctl[4]) & $past(clkpin_ctl[6]) & ~$past(obd[3]));
  endproperty
  a_clkin: assert property (p_clkin)
    else $error("data clock input enable wrong");

  property p_bandgap;
    @(posedge clk_sys) disable iff (!rst_n)
    power_ctl.bandgap_off |-> $past(whole_chip_sleep)
      && $past(sleep_mask[1]);
  endproperty
  a_bandgap: assert property (p_bandgap)
    else $error("bandgap off outside masked sleep");

  c_sleep: cover property (@(posedge clk_sys) disable iff (!rst_n)
    wr_pwr && req.data[0]);
  c_low: cover property (@(posedge clk_sys) disable iff (!rst_n)
    wr_low);
  c_read: cover property (@(posedge clk_sys) disable iff (!rst_n)
    sdio_oe);
  c_masked: cover property (@(posedge clk_sys) disable iff (!rst_n)
    whole_chip_sleep && sleep_mask[3] && sleep_mask[2]);
  c_clkin: cover property (@(posedge clk_sys) disable iff (!rst_n)
    pin_ctl.data_clock_input_pin_en);

endmodule

/* File: verilog/pdobr_pkg.sv */
package pdobr_pkg;

  // -----------------------------------------------------------------
  // Serial frame layout
  // -----------------------------------------------------------------
  localparam int         FRAME_BITS = 16;
  localparam logic [3:0] CNT_ADDR_LAST  = 4'h7;
  localparam logic [3:0] CNT_FRAME_LAST = 4'hf;

  // -----------------------------------------------------------------
  // Register offsets
  // -----------------------------------------------------------------
  localparam logic [6:0] ADDR_POWER       = 7'h08;
  localparam logic [6:0] ADDR_OBD_LOW     = 7'h0a;
  localparam logic [6:0] ADDR_OBD_MID     = 7'h0b;
  localparam logic [6:0] ADDR_OBD_HIGH    = 7'h0c;
  localparam logic [6:0] ADDR_SLEEP_MASK  = 7'h0d;
  localparam logic [6:0] ADDR_CLKIN_CTL   = 7'h18;
  localparam logic [6:0] ADDR_CLKPIN_CTL  = 7'h1f;

  localparam logic [7:0]  RESET_BYTE = 8'h00;
  localparam logic [23:0] RESET_OBD  = 24'h000000;
  localparam logic [7:0]  READ_UNMAPPED = 8'h00;

  // -----------------------------------------------------------------
  // Field positions
  // -----------------------------------------------------------------
  localparam int PWR_CLKBUF  = 5;
  localparam int PWR_AMP     = 4;
  localparam int PWR_CHAN_A  = 2;
  localparam int PWR_CHAN_B  = 1;
  localparam int PWR_GLOBAL  = 0;
  localparam int MASK_CLKBUF = 3;
  localparam int MASK_AMP    = 2;
  localparam int MASK_BGAP   = 1;
  localparam int CLKIN_EN_18 = 4;
  localparam int CLKIN_EN_1F = 6;
  localparam int CLKOUT_OFF  = 4;
  // Positions inside the 24-bit buffer disable field
  localparam int OBD_B5    = 7;
  localparam int OBD_CLKIN = 3;
  localparam int OBD_FRAME = 12;
  localparam int OBD_B6    = 8;
  localparam int OBD_A6    = 17;
  localparam int OBD_A5    = 16;

  // -----------------------------------------------------------------
  // Recommended buffer disable values per interface mode
  // -----------------------------------------------------------------
  localparam logic [23:0] OBD_TWO_WIRE  = 24'hfcee7f;
  localparam logic [23:0] OBD_ONE_WIRE  = 24'hfdeeff;
  localparam logic [23:0] OBD_HALF_WIRE = 24'hfdefff;

  // -----------------------------------------------------------------
  // Carriers
  // -----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic [6:0] addr;
    logic [7:0] data;
  } pdobr_req_t;

  typedef struct packed {
    logic sample_clock_buffer_off;
    logic reference_amplifier_off;
    logic bandgap_off;
    logic channel_first_off;
    logic channel_second_off;
  } pdobr_power_t;

  typedef struct packed {
    logic data_clock_input_pin_en;
    logic data_clock_output_pin_off;
    logic frame_clock_pin_off;
    logic second_channel_line_five_off;
    logic second_channel_line_six_off;
    logic first_channel_line_five_off;
    logic first_channel_line_six_off;
  } pdobr_pins_t;

endpackage

/* File: verilog/pdobr_serial_port.sv */
module pdobr_serial_port (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              sclk,
  input  wire logic              sen_n,
  input  wire logic              sdio_in,
  input  wire logic [7:0]        rd_data,
  output pdobr_pkg::pdobr_req_t  req,
  output logic                   req_valid,
  output logic [6:0]             rd_addr,
  output logic                   sdio_out,
  output logic                   sdio_oe
);

  logic        sclk_q;
  logic [14:0] shift;
  logic [3:0]  bit_cnt;
  logic        rd_load;
  logic        rd_active;
  logic [7:0]  out_shift;
  logic        sclk_rise;
  logic        sclk_fall;
  logic [15:0] word;

  assign sclk_rise = sclk & ~sclk_q & ~sen_n;
  assign sclk_fall = ~sclk & sclk_q & ~sen_n;
  assign word      = {shift, sdio_in};

  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      sclk_q <= 1'b0;
    else
      sclk_q <= sclk;

  // -----------------------------------------------------------------
  // Input shifter
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      shift   <= 15'h0000;
      bit_cnt <= 4'h0;
    end
    else if (sen_n)
      bit_cnt <= 4'h0;
    else if (sclk_rise)
    begin
      shift   <= word[14:0];
      bit_cnt <= bit_cnt + 4'h1;
    end

  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      req_valid <= 1'b0;
      req       <= '0;
    end
    else
    begin
      req_valid <= sclk_rise && (bit_cnt == pdobr_pkg::CNT_FRAME_LAST);
      if (sclk_rise && (bit_cnt == pdobr_pkg::CNT_FRAME_LAST))
      begin
        req.wr   <= ~word[15];
        req.addr <= word[14:8];
        req.data <= word[7:0];
      end
    end

  // -----------------------------------------------------------------
  // Read return
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      rd_addr <= 7'h00;
      rd_load <= 1'b0;
    end
    else
    begin
      rd_load <= sclk_rise && (bit_cnt == pdobr_pkg::CNT_ADDR_LAST)
                 && word[7];
      if (sclk_rise && (bit_cnt == pdobr_pkg::CNT_ADDR_LAST))
        rd_addr <= word[6:0];
    end

  // Data changes on the falling edge so the host samples it stable
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      out_shift <= 8'h00;
      rd_active <= 1'b0;
      sdio_out  <= 1'b0;
      sdio_oe   <= 1'b0;
    end
    else if (sen_n)
    begin
      rd_active <= 1'b0;
      sdio_oe   <= 1'b0;
      sdio_out  <= 1'b0;
    end
    else if (rd_load)
    begin
      out_shift <= rd_data;
      rd_active <= 1'b1;
    end
    else if (sclk_fall && rd_active)
    begin
      sdio_out  <= out_shift[7];
      out_shift <= {out_shift[6:0], 1'b0};
      sdio_oe   <= 1'b1;
    end

endmodule

/* File: bench/pdobr_regs_test.sv */
module pdobr_regs_test;
  timeunit 1ns;
  timeprecision 100ps;

  // ---------------------------------------------------------------
  // Device under test and stimulus
  // ---------------------------------------------------------------
  logic                    clk_sys;
  logic                    rst_n;
  logic                    sclk;
  logic                    sen_n;
  logic                    sdio_in;
  logic                    sdio_out;
  logic                    sdio_oe;
  pdobr_pkg::pdobr_power_t power_ctl;
  pdobr_pkg::pdobr_pins_t  pin_ctl;
  logic [23:0]             output_driver_disable_bits;
  int                      n_fail;
  int                      checks;
  // Shadow copy of what software has written
  logic [7:0]              s_pwr;
  logic [7:0]              s_msk;
  logic [7:0]              s_r18;
  logic [7:0]              s_r1f;
  logic [23:0]             s_obd;

  pdobr_regs uut (
    .clk_sys                    (clk_sys),
    .rst_n                      (rst_n),
    .sclk                       (sclk),
    .sen_n                      (sen_n),
    .sdio_in                    (sdio_in),
    .sdio_out                   (sdio_out),
    .sdio_oe                    (sdio_oe),
    .power_ctl                  (power_ctl),
    .pin_ctl                    (pin_ctl),
    .output_driver_disable_bits (output_driver_disable_bits)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // ---------------------------------------------------------------
  // Expectations and comparison
  // ---------------------------------------------------------------
  function automatic pdobr_pkg::pdobr_power_t exp_power();
    pdobr_pkg::pdobr_power_t p;
    p.sample_clock_buffer_off = s_pwr[5] | (s_pwr[0] & ~s_msk[3]);
    p.reference_amplifier_off = s_pwr[4] | (s_pwr[0] & ~s_msk[2]);
    p.bandgap_off             = s_pwr[0] & s_msk[1];
    p.channel_first_off       = s_pwr[2] | s_pwr[0];
    p.channel_second_off      = s_pwr[1] | s_pwr[0];
    return p;
  endfunction

  function automatic pdobr_pkg::pdobr_pins_t exp_pins();
    pdobr_pkg::pdobr_pins_t q;
    q.data_clock_input_pin_en      = s_r18[4] & s_r1f[6] & ~s_obd[3];
    q.data_clock_output_pin_off    = s_r1f[4];
    q.frame_clock_pin_off          = s_obd[12];
    q.second_channel_line_five_off = s_obd[7];
    q.second_channel_line_six_off  = s_obd[8];
    q.first_channel_line_five_off  = s_obd[16];
    q.first_channel_line_six_off   = s_obd[17];
    return q;
  endfunction

  function automatic logic [7:0] shadow_of(input logic [6:0] a);
    case (a)
      pdobr_pkg::ADDR_POWER:      return s_pwr;
      pdobr_pkg::ADDR_OBD_LOW:    return s_obd[7:0];
      pdobr_pkg::ADDR_OBD_MID:    return s_obd[15:8];
      pdobr_pkg::ADDR_OBD_HIGH:   return s_obd[23:16];
      pdobr_pkg::ADDR_SLEEP_MASK: return s_msk;
      pdobr_pkg::ADDR_CLKIN_CTL:  return s_r18;
      pdobr_pkg::ADDR_CLKPIN_CTL: return s_r1f;
      default:                    return pdobr_pkg::READ_UNMAPPED;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [23:0] e,
                     input logic [23:0] g);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic check_outs();
    chk("power_ctl", 24'(exp_power()), 24'(power_ctl));
    chk("pin_ctl", 24'(exp_pins()), 24'(pin_ctl));
    chk("disable_bits", s_obd, output_driver_disable_bits);
  endtask

  // ---------------------------------------------------------------
  // Serial port driver
  // ---------------------------------------------------------------
  // Four clocks low and three high keep both phases above the two-clock minimum
  task automatic frame(input logic [15:0] w, input int n,
                       output logic [7:0] q);
    q = 8'h00;
    for (int i = 15; i > 15 - n; i--)
    begin
      @(posedge clk_sys);
      sclk    <= 1'b0;
      sdio_in <= w[i];
      repeat (3) @(posedge clk_sys);
      #1;
      if (w[15] && i < 8)
      begin
        q[i] = sdio_out;
        chk("sdio_oe", 24'h000001, 24'(sdio_oe));
      end
      @(posedge clk_sys);
      sclk <= 1'b1;
      repeat (2) @(posedge clk_sys);
    end
  endtask

  task automatic open_frame();
    @(posedge clk_sys);
    sen_n <= 1'b0;
  endtask

  task automatic close_frame();
    @(posedge clk_sys);
    sen_n   <= 1'b1;
    sdio_in <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask

  task automatic note_write(input logic [6:0] a, input logic [7:0] d);
    case (a)
      pdobr_pkg::ADDR_POWER:      s_pwr = d;
      pdobr_pkg::ADDR_OBD_LOW:    s_obd[7:0] = d;
      pdobr_pkg::ADDR_OBD_MID:    s_obd[15:8] = d;
      pdobr_pkg::ADDR_OBD_HIGH:   s_obd[23:16] = d;
      pdobr_pkg::ADDR_SLEEP_MASK: s_msk = d;
      pdobr_pkg::ADDR_CLKIN_CTL:  s_r18 = d;
      pdobr_pkg::ADDR_CLKPIN_CTL: s_r1f = d;
      default: ;
    endcase
  endtask

  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    open_frame();
    frame({1'b0, a, d}, 16, q);
    close_frame();
    note_write(a, d);
  endtask

  task automatic rd_reg(input logic [6:0] a);
    logic [7:0] q;
    open_frame();
    frame({1'b1, a, 8'h00}, 16, q);
    close_frame();
    chk("read data", 24'(shadow_of(a)), 24'(q));
  endtask

  task automatic wr_obd(input logic [23:0] v);
    wr_reg(pdobr_pkg::ADDR_OBD_LOW, v[7:0]);
    wr_reg(pdobr_pkg::ADDR_OBD_MID, v[15:8]);
    wr_reg(pdobr_pkg::ADDR_OBD_HIGH, v[23:16]);
  endtask

  task automatic do_reset();
    @(posedge clk_sys);
    rst_n <= 1'b0;
    #1;
    s_pwr = 8'h00;
    s_msk = 8'h00;
    s_r18 = 8'h00;
    s_r1f = 8'h00;
    s_obd = 24'h000000;
    check_outs();
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_values();
    logic [6:0] adr [8];
    adr = '{7'h08, 7'h0a, 7'h0b, 7'h0c, 7'h0d, 7'h18, 7'h1f, 7'h09};
    check_outs();
    foreach (adr[i]) rd_reg(adr[i]);
  endtask

  task automatic t_power_bits();
    int pos [4];
    pos = '{5, 4, 2, 1};
    foreach (pos[i])
    begin
      wr_reg(pdobr_pkg::ADDR_POWER, 8'h01 << pos[i]);
      check_outs();
      rd_reg(pdobr_pkg::ADDR_POWER);
    end
    wr_reg(pdobr_pkg::ADDR_POWER, 8'h36);
    check_outs();
    wr_reg(pdobr_pkg::ADDR_POWER, 8'h00);
    check_outs();
  endtask

  task automatic t_sleep_mask();
    logic [7:0] m [5];
    m = '{8'h00, 8'h08, 8'h04, 8'h02, 8'h0e};
    foreach (m[i])
    begin
      wr_reg(pdobr_pkg::ADDR_SLEEP_MASK, m[i]);
      check_outs();
      wr_reg(pdobr_pkg::ADDR_POWER, 8'h01);
      check_outs();
      wr_reg(pdobr_pkg::ADDR_POWER, 8'h00);
      check_outs();
    end
  endtask

  task automatic t_modes();
    logic [23:0] tbl [3];
    int          pos [6];
    tbl = '{pdobr_pkg::OBD_TWO_WIRE, pdobr_pkg::OBD_ONE_WIRE,
            pdobr_pkg::OBD_HALF_WIRE};
    pos = '{pdobr_pkg::OBD_B5, pdobr_pkg::OBD_CLKIN, pdobr_pkg::OBD_FRAME,
            pdobr_pkg::OBD_B6, pdobr_pkg::OBD_A6, pdobr_pkg::OBD_A5};
    foreach (tbl[i])
    begin
      // Mode register lives outside this block; the write must be ignored
      wr_reg(7'h07, 8'h0b);
      wr_obd(tbl[i]);
      check_outs();
      rd_reg(pdobr_pkg::ADDR_OBD_LOW);
      rd_reg(pdobr_pkg::ADDR_OBD_MID);
      rd_reg(pdobr_pkg::ADDR_OBD_HIGH);
    end
    foreach (pos[i])
    begin
      wr_obd(24'h000001 << pos[i]);
      check_outs();
    end
    wr_obd(24'h000000);
    check_outs();
  endtask

  task automatic t_clock_pins();
    wr_reg(pdobr_pkg::ADDR_CLKIN_CTL, 8'h10);
    check_outs();
    wr_reg(pdobr_pkg::ADDR_CLKPIN_CTL, 8'h40);
    check_outs();
    wr_reg(pdobr_pkg::ADDR_CLKPIN_CTL, 8'h50);
    check_outs();
    wr_reg(pdobr_pkg::ADDR_OBD_LOW, 8'h08);
    check_outs();
    rd_reg(pdobr_pkg::ADDR_CLKPIN_CTL);
    rd_reg(pdobr_pkg::ADDR_CLKIN_CTL);
  endtask

  task automatic t_refused();
    logic [7:0] q;
    wr_reg(7'h09, 8'hff);
    wr_reg(7'h7f, 8'hff);
    rd_reg(7'h09);
    rd_reg(7'h7f);
    // Frame cut short after ten bits must leave the power register alone
    open_frame();
    frame({1'b0, pdobr_pkg::ADDR_POWER, 8'h3f}, 10, q);
    close_frame();
    check_outs();
    wr_reg(pdobr_pkg::ADDR_POWER, 8'hc8);
    check_outs();
    rd_reg(pdobr_pkg::ADDR_POWER);
  endtask

  task automatic t_back_to_back();
    logic [7:0] q;
    open_frame();
    frame({1'b0, pdobr_pkg::ADDR_POWER, 8'h24}, 16, q);
    frame({1'b0, pdobr_pkg::ADDR_OBD_MID, 8'h11}, 16, q);
    close_frame();
    note_write(pdobr_pkg::ADDR_POWER, 8'h24);
    note_write(pdobr_pkg::ADDR_OBD_MID, 8'h11);
    check_outs();
  endtask

  task automatic t_mid_reset();
    wr_reg(pdobr_pkg::ADDR_SLEEP_MASK, 8'h0e);
    wr_reg(pdobr_pkg::ADDR_POWER, 8'h01);
    do_reset();
    check_outs();
    rd_reg(pdobr_pkg::ADDR_SLEEP_MASK);
    rd_reg(pdobr_pkg::ADDR_OBD_MID);
  endtask

  // ---------------------------------------------------------------
  // Run control
  // ---------------------------------------------------------------
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    n_fail  = 0;
    checks  = 0;
    rst_n   = 1'b0;
    sclk    = 1'b0;
    sen_n   = 1'b1;
    sdio_in = 1'b0;
    do_reset();
    t_reset_values();
    t_power_bits();
    t_sleep_mask();
    t_modes();
    t_clock_pins();
    t_refused();
    t_back_to_back();
    t_mid_reset();
    print_verdict();
  end

  // Roughly 90 frames of about 110 clocks each are expected
  initial
  begin
    #200000;
    n_fail++;
    $display("[ERR] watchdog expected done seen running");
    print_verdict();
  end
endmodule
